//--- rtl/serial_ctrl_pkg.sv
/*
 * serial_ctrl_pkg: register map, field positions, reset values and
 * shared types of the serial port control block.
 * assumes: 32-bit apb, registers one per aligned word at index * 4.
 */
package serial_ctrl_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [31:0] IDX_PRIO   = 32'h0000ff21;
    localparam logic [31:0] IDX_IRQ_EN = 32'h0000ff24;
    localparam logic [31:0] IDX_FLAGS  = 32'h0000ff28;
    localparam logic [31:0] IDX_TIMER  = 32'h0000ff38;
    localparam logic [31:0] IDX_CFG    = 32'h0000ff40;

    localparam logic [31:0] ADDR_PRIO   = {IDX_PRIO[29:0], 2'b00};
    localparam logic [31:0] ADDR_IRQ_EN = {IDX_IRQ_EN[29:0], 2'b00};
    localparam logic [31:0] ADDR_FLAGS  = {IDX_FLAGS[29:0], 2'b00};
    localparam logic [31:0] ADDR_TIMER  = {IDX_TIMER[29:0], 2'b00};
    localparam logic [31:0] ADDR_CFG    = {IDX_CFG[29:0], 2'b00};

    // interrupt priority levels: two-bit field
    localparam int PRIO_LSB = 4;
    localparam logic [1:0] PRIO_RST = 2'h0;

    // enable bits and factor flags share one layout
    localparam int EVT_FAULT = 0;
    localparam int EVT_RX    = 1;
    localparam int EVT_TX    = 2;
    localparam logic [2:0] EVT_RST = 3'h0;

    // timer output control
    localparam int TIMER_GATE_BIT = 2;
    localparam logic TIMER_GATE_RST = 1'b0;

    // serial configuration fields
    localparam int CFG_PINS_EN   = 0;
    localparam int CFG_MODE_LSB  = 1;
    localparam int CFG_STOP      = 4;
    localparam int CFG_PAR_ODD   = 5;
    localparam int CFG_PAR_ON    = 6;
    localparam int CFG_GROUP     = 7;
    localparam logic [7:0] CFG_WMASK = 8'hf7;
    localparam logic [7:0] CFG_RST   = 8'h00;

    // level seen by the engine while the pins act as ports
    localparam logic [3:0] SER_IN_IDLE = 4'hf;

    typedef enum logic [1:0] {
        MODE_CLK_MASTER = 2'b00,
        MODE_CLK_SLAVE  = 2'b01,
        MODE_ASYNC7     = 2'b10,
        MODE_ASYNC8     = 2'b11
    } xfer_mode_t;

    typedef struct packed {
        xfer_mode_t mode;
        logic       is_async;
        logic       data8;
        logic       parity_on;
        logic       parity_odd;
        logic       stop_two;
    } frame_cfg_t;

    localparam frame_cfg_t FRAME_RST = '{
        mode: MODE_CLK_MASTER, is_async: 1'b0, data8: 1'b1,
        parity_on: 1'b0, parity_odd: 1'b0, stop_two: 1'b0};

endpackage

//--- rtl/serial_clk_div.sv
/*
 * serial_clk_div: gates the timer underflow into the serial interface
 * and halves its rate, giving a one-cycle enable pulse.
 * assumes: underflow is a one-cycle pulse on clk.
 */
`timescale 1ns/10ps
module serial_clk_div
    import serial_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // control and timer
    input  wire logic gate,
    input  wire logic underflow,
    // rate out
    output logic      clk_en
);

    logic half_q;
    logic half_d;
    logic en_q;
    logic en_d;

    // phase restarts whenever the gate closes, so the first pulse after
    // opening always comes on the second underflow
    always_comb begin
        half_d = half_q;
        en_d   = 1'b0;
        if (!gate) begin
            half_d = 1'b0;
        end else if (underflow) begin
            half_d = ~half_q;
            en_d   = half_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            half_q <= 1'b0;
            en_q   <= 1'b0;
        end else begin
            half_q <= half_d;
            en_q   <= en_d;
        end
    end

    assign clk_en = en_q;

endmodule

//--- rtl/serial_port_control.sv
/*
 * serial_port_control: apb register file for the serial interface
 * control bits, interrupt flags, timer clock gating and pin routing.
 * assumes: event inputs are one-cycle pulses on clk from the shift
 * engine; pad inputs are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps

// Contract
// - two-bit mode selects master, slave, async7, async8
// - parity enable adds parity bit, resets off
// - parity mode one is odd, zero even
// - stop bit one means two stops, else one
// - group bit picks upper or lower four pins
// - three enables gate tx, rx, fault interrupts
// - event flags set, write one clears them
// - timer clock gate passes clock, resets off
// - interface enable hands pins to serial logic
// - serial clock is timer underflow halved
// - stop length ignored in clocked modes
module serial_port_control
    import serial_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // shift engine events and frame setup
    input  wire logic        tx_done_evt,
    input  wire logic        rx_done_evt,
    input  wire logic        rx_fault_evt,
    output frame_cfg_t       frame_cfg,
    // timer
    input  wire logic        timer_underflow,
    output logic             ser_clk_en,
    // engine and port signals to route
    input  wire logic [3:0]  ser_out,
    input  wire logic [3:0]  ser_oe,
    output logic      [3:0]  ser_in,
    input  wire logic [7:0]  gpio_out,
    input  wire logic [7:0]  gpio_oe,
    output logic      [7:0]  gpio_in,
    // pads
    input  wire logic [7:0]  pad_in,
    output logic      [7:0]  pad_out,
    output logic      [7:0]  pad_oe,
    // interrupt
    output logic             irq,
    output logic      [1:0]  irq_level
);

    function automatic logic [7:0] put_field(input logic [7:0] v);
        return v;
    endfunction

    // apb group
    logic        setup;
    logic        wr;
    logic        hit;
    logic [7:0]  rdata;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        pready_q;
    logic        pready_d;
    logic        pslverr_q;
    logic        pslverr_d;

    // register group
    logic [1:0]  prio_q;
    logic [1:0]  prio_d;
    logic [2:0]  irq_en_q;
    logic [2:0]  irq_en_d;
    logic [2:0]  flags_q;
    logic [2:0]  flags_d;
    logic        gate_q;
    logic        gate_d;
    logic [7:0]  cfg_q;
    logic [7:0]  cfg_d;
    logic        irq_q;
    logic        irq_d;
    frame_cfg_t  frame_q;
    frame_cfg_t  frame_d;

    // pin group
    logic [7:0]  pad_s1_q;
    logic [7:0]  pad_s2_q;
    logic [3:0]  ser_in_q;
    logic [3:0]  ser_in_d;
    logic [7:0]  gpio_in_q;
    logic [7:0]  pad_out_q;
    logic [7:0]  pad_out_d;
    logic [7:0]  pad_oe_q;
    logic [7:0]  pad_oe_d;

    xfer_mode_t  mode;

    // zero-wait slave: setup cycle prepares the answer, access completes
    always_comb begin
        setup = psel && !penable;
        wr    = psel && penable && pready_q && pwrite;
        hit   = 1'b1;
        rdata = 8'h00;
        case (paddr)
            ADDR_PRIO:   rdata[PRIO_LSB +: 2] = prio_q;
            ADDR_IRQ_EN: rdata[2:0] = irq_en_q;
            ADDR_FLAGS:  rdata[2:0] = flags_q;
            ADDR_TIMER:  rdata[TIMER_GATE_BIT] = gate_q;
            ADDR_CFG:    rdata = cfg_q & CFG_WMASK;
            default:     hit = 1'b0;
        endcase
        pready_d  = setup;
        pslverr_d = setup && !hit;
        prdata_d  = 32'h0;
        if (setup && !pwrite) begin
            prdata_d = {24'h0, put_field(rdata)};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prdata_q  <= 32'h0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // registers, flags and derived frame setup
    always_comb begin
        prio_d   = prio_q;
        irq_en_d = irq_en_q;
        gate_d   = gate_q;
        cfg_d    = cfg_q;
        flags_d  = flags_q;
        if (wr) begin
            case (paddr)
                ADDR_PRIO:   prio_d = pwdata[PRIO_LSB +: 2];
                ADDR_IRQ_EN: irq_en_d = pwdata[2:0];
                ADDR_FLAGS:  flags_d = flags_q & ~pwdata[2:0];
                ADDR_TIMER:  gate_d = pwdata[TIMER_GATE_BIT];
                ADDR_CFG:    cfg_d = pwdata[7:0] & CFG_WMASK;
                default:     cfg_d = cfg_q;
            endcase
        end
        // an event in the clearing cycle still lands
        flags_d[EVT_TX]    = flags_d[EVT_TX] | tx_done_evt;
        flags_d[EVT_RX]    = flags_d[EVT_RX] | rx_done_evt;
        flags_d[EVT_FAULT] = flags_d[EVT_FAULT] | rx_fault_evt;
        irq_d = |(flags_q & irq_en_q);

        mode = xfer_mode_t'(cfg_q[CFG_MODE_LSB +: 2]);
        frame_d.mode       = mode;
        frame_d.is_async   = 1'b0;
        frame_d.data8      = 1'b1;
        case (mode)
            MODE_ASYNC8: frame_d.is_async = 1'b1;
            MODE_ASYNC7: begin
                frame_d.is_async = 1'b1;
                frame_d.data8    = 1'b0;
            end
            MODE_CLK_SLAVE:  frame_d.is_async = 1'b0;
            MODE_CLK_MASTER: frame_d.is_async = 1'b0;
            default:         frame_d.is_async = 1'b0;
        endcase
        frame_d.parity_on  = cfg_q[CFG_PAR_ON];
        frame_d.parity_odd = cfg_q[CFG_PAR_ODD];
        // the two-stop setting is forced off for clocked transfers
        frame_d.stop_two   = cfg_q[CFG_STOP] && frame_d.is_async;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prio_q   <= PRIO_RST;
            irq_en_q <= EVT_RST;
            flags_q  <= EVT_RST;
            gate_q   <= TIMER_GATE_RST;
            cfg_q    <= CFG_RST;
            irq_q    <= 1'b0;
            frame_q  <= FRAME_RST;
        end else begin
            prio_q   <= prio_d;
            irq_en_q <= irq_en_d;
            flags_q  <= flags_d;
            gate_q   <= gate_d;
            cfg_q    <= cfg_d;
            irq_q    <= irq_d;
            frame_q  <= frame_d;
        end
    end

    // pin routing; the unused group stays an ordinary port
    always_comb begin
        pad_out_d = gpio_out;
        pad_oe_d  = gpio_oe;
        ser_in_d  = SER_IN_IDLE;
        if (cfg_q[CFG_PINS_EN]) begin
            if (cfg_q[CFG_GROUP]) begin
                pad_out_d[7:4] = ser_out;
                pad_oe_d[7:4]  = ser_oe;
                ser_in_d       = pad_s2_q[7:4];
            end else begin
                pad_out_d[3:0] = ser_out;
                pad_oe_d[3:0]  = ser_oe;
                ser_in_d       = pad_s2_q[3:0];
            end
        end
    end

    // two-stage sync first; only stage two is read
    always_ff @(posedge clk) begin
        if (reset) begin
            pad_s1_q  <= 8'h00;
            pad_s2_q  <= 8'h00;
            ser_in_q  <= SER_IN_IDLE;
            gpio_in_q <= 8'h00;
            pad_out_q <= 8'h00;
            pad_oe_q  <= 8'h00;
        end else begin
            pad_s1_q  <= pad_in;
            pad_s2_q  <= pad_s1_q;
            ser_in_q  <= ser_in_d;
            gpio_in_q <= pad_s2_q;
            pad_out_q <= pad_out_d;
            pad_oe_q  <= pad_oe_d;
        end
    end

    serial_clk_div u_clk_div (
        .clk       (clk),
        .reset     (reset),
        .gate      (gate_q),
        .underflow (timer_underflow),
        .clk_en    (ser_clk_en)
    );

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign frame_cfg = frame_q;
    assign ser_in    = ser_in_q;
    assign gpio_in   = gpio_in_q;
    assign pad_out   = pad_out_q;
    assign pad_oe    = pad_oe_q;
    assign irq       = irq_q;
    assign irq_level = prio_q;

endmodule

//--- testbench/serial_port_control_properties.sv
/* checker for serial_port_control: apb timing, irq cause, rate, frame.
   assumes: bound to the top module ports, one clock domain. */
`timescale 1ns/10ps
module serial_port_control_chk
    import serial_ctrl_pkg::*;
(
    // clock, reset and apb
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    // events and outputs
    input wire logic        tx_done_evt,
    input wire logic        rx_done_evt,
    input wire logic        rx_fault_evt,
    input wire frame_cfg_t  frame_cfg,
    input wire logic        timer_underflow,
    input wire logic        ser_clk_en,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic  wr_done = psel && penable && pready && pwrite;
    wire logic  any_evt = tx_done_evt || rx_done_evt || rx_fault_evt;
    logic [1:0] uf_q;
    logic [1:0] uf_d;
    // underflows seen since the last rate pulse, saturating
    always_comb begin
        uf_d = uf_q;
        if (ser_clk_en) begin
            uf_d = {1'b0, timer_underflow};
        end else if (timer_underflow && uf_q != 2'h3) begin
            uf_d = uf_q + 2'h1;
        end
    end
    always_ff @(posedge clk) begin
        uf_q <= reset ? 2'h0 : uf_d;
    end
    chk_ready_timing: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    chk_rdata_idle: assert property (!pready || pwrite |-> prdata == 32'h0)
        else $error("read data outside read answer");
    chk_rdata_upper: assert property (
        pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    chk_irq_cause: assert property (
        $rose(irq) |-> $past(any_evt, 2) ||
        $past(wr_done && paddr == ADDR_IRQ_EN, 2))
        else $error("irq rose without cause");
    chk_irq_clear: assert property (
        $fell(irq) |-> $past(wr_done &&
        (paddr == ADDR_FLAGS || paddr == ADDR_IRQ_EN), 2))
        else $error("irq fell without write");
    chk_rate_half: assert property (ser_clk_en |-> uf_q >= 2'h2)
        else $error("rate pulse before second underflow");
    chk_rate_cause: assert property (
        ser_clk_en |-> $past(timer_underflow))
        else $error("rate pulse without underflow");
    chk_stop_sync: assert property (
        !frame_cfg.is_async |-> !frame_cfg.stop_two)
        else $error("two stops in clocked mode");
    chk_mode_decode: assert property (
        frame_cfg.is_async == frame_cfg.mode[1] &&
        frame_cfg.data8 == (frame_cfg.mode != MODE_ASYNC7))
        else $error("mode decode wrong");
    chk_parity_apply: assert property (
        wr_done && paddr == ADDR_CFG |-> ##2
        {frame_cfg.parity_on, frame_cfg.parity_odd} == $past(pwdata[6:5], 2))
        else $error("parity setup not applied");
    cover property (wr_done && paddr == ADDR_CFG);
    cover property ($rose(irq));
    cover property (ser_clk_en);
endmodule

//--- testbench/serial_remote.sv
/* serial_remote: far serial device on the eight pads.
   assumes: pads pulled up; the bench sets what the far side drives. */
`timescale 1ns/10ps
module serial_remote (
    // pads seen from the far side
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] far_drive,
    input  wire logic [7:0] far_oe,
    output logic      [7:0] pad_in
);
    // released lines float to the pull-up level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad_oe[i]) pad_in[i] = pad_out[i];
            else if (far_oe[i]) pad_in[i] = far_drive[i];
            else pad_in[i] = 1'b1;
        end
    end
endmodule

//--- testbench/tb_serial_port_control.sv
/* tb_serial_port_control: self-checking bench, apb master and far side.
   assumes: design and package compiled first. */
`timescale 1ns/10ps
module tb_serial_port_control
    import serial_ctrl_pkg::*;
;
    logic        clk, reset, psel, penable, pwrite, uflow;
    logic [31:0] paddr, pwdata, prdata, seed, r;
    logic        pready, pslverr, ser_clk_en, irq;
    logic [2:0]  evt;
    logic [3:0]  ser_out, ser_oe, ser_in;
    logic [7:0]  gpio_out, gpio_oe, gpio_in, pad_in, pad_out, pad_oe;
    logic [7:0]  far_drive, far_oe;
    logic [1:0]  irq_level;
    frame_cfg_t  frame_cfg;
    logic [32:0] exp_q[$];
    int          fails, check_count, clk_seen;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    serial_port_control i_dut (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_done_evt(evt[EVT_TX]),
        .rx_done_evt(evt[EVT_RX]), .rx_fault_evt(evt[EVT_FAULT]),
        .frame_cfg(frame_cfg), .timer_underflow(uflow),
        .ser_clk_en(ser_clk_en), .ser_out(ser_out), .ser_oe(ser_oe),
        .ser_in(ser_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .gpio_in(gpio_in), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .irq(irq), .irq_level(irq_level));
    serial_remote i_far (.pad_out(pad_out), .pad_oe(pad_oe),
        .far_drive(far_drive), .far_oe(far_oe), .pad_in(pad_in));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [31:0] a, d, e,
                        input logic er);
        int n;
        n = 0;
        exp_q.push_back({er, e});
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            fails++;
            $display("CHECK FAILED at %0t: no apb answer", $time);
            give_verdict();
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge clk);
            uflow <= 1'b1;
            @(posedge clk);
            uflow <= 1'b0;
            @(posedge clk);
        end
    endtask
    // answers are matched against the oldest note
    always @(posedge clk) begin
        if (pready === 1'b1) begin
            check(prdata, exp_q[0][31:0]);
            check({31'h0, pslverr}, {31'h0, exp_q[0][32]});
            void'(exp_q.pop_front());
        end
        if (ser_clk_en === 1'b1) clk_seen++;
    end
    initial begin
        #200000;
        fails++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        give_verdict();
    end
    initial begin
        {psel, penable, pwrite, uflow, evt} = 7'h00;
        {paddr, pwdata, ser_out, ser_oe} = 72'h0;
        {gpio_out, gpio_oe, far_drive, far_oe} = 32'h0;
        {fails, check_count, clk_seen} = 96'h0;
        seed = 32'h00000030;
        reset = 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        exp_q.delete();
        xfer(0, ADDR_PRIO, 0, 0, 0);
        xfer(0, ADDR_IRQ_EN, 0, 0, 0);
        xfer(0, ADDR_FLAGS, 0, 0, 0);
        xfer(0, ADDR_TIMER, 0, 0, 0);
        xfer(0, ADDR_CFG, 0, 0, 0);
        xfer(1, ADDR_CFG + 32'h4, 32'hff, 0, 1);
        r = rnd();
        xfer(1, ADDR_PRIO, r, 0, 0);
        xfer(0, ADDR_PRIO, 0, r & 32'h30, 0);
        step(2);
        check(32'(irq_level), 32'(r[5:4]));
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            r = rnd();
            r[2:1] = m[1:0];
            xfer(1, ADDR_CFG, r, 0, 0);
            xfer(0, ADDR_CFG, 0, r & 32'hf7, 0);
            step(2);
            check(32'(frame_cfg.mode), 32'(m));
            check(32'(frame_cfg.stop_two),
                  32'(r[4] & r[2]));
            check(32'({frame_cfg.parity_on,
                       frame_cfg.parity_odd}), 32'(r[6:5]));
        end
        $display("test modes done");
        @(posedge clk);
        evt <= 3'h7;
        @(posedge clk);
        evt <= 3'h0;
        step(2);
        check(32'(irq), 32'h0);
        xfer(1, ADDR_FLAGS, 0, 0, 0);
        xfer(0, ADDR_FLAGS, 0, 32'h7, 0);
        for (int i = 0; i < 3; i++) begin
            xfer(1, ADDR_IRQ_EN, 32'h1 << i, 0, 0);
            step(2);
            check(32'(irq), 32'h1);
            xfer(1, ADDR_FLAGS, 32'h1 << i, 0, 0);
            step(2);
            check(32'(irq), 32'h0);
        end
        xfer(0, ADDR_FLAGS, 0, 0, 0);
        $display("test events done");
        tick(4);
        check(clk_seen, 0);
        xfer(1, ADDR_TIMER, 32'h4, 0, 0);
        xfer(0, ADDR_TIMER, 0, 32'h4, 0);
        tick(6);
        step(2);
        check(clk_seen, 3);
        $display("test timer done");
        xfer(1, ADDR_CFG, 0, 0, 0);
        r = rnd();
        @(posedge clk);
        {far_drive, gpio_oe, gpio_out} <= r[23:0];
        far_oe <= ~r[15:8];
        step(4);
        check(32'(pad_oe), 32'(r[15:8]));
        check(32'(gpio_in),
              32'((r[7:0] & r[15:8]) | (r[23:16] & ~r[15:8])));
        xfer(1, ADDR_CFG, 32'h1, 0, 0);
        ser_out <= r[27:24];
        ser_oe <= 4'hf;
        step(3);
        check(32'({pad_oe[3:0], pad_out[3:0]}),
              32'({4'hf, r[27:24]}));
        @(posedge clk);
        gpio_oe <= 8'h00;
        ser_oe <= 4'h0;
        far_oe <= 8'hff;
        xfer(1, ADDR_CFG, 32'h81, 0, 0);
        step(4);
        check(32'(ser_in), 32'(r[23:20]));
        $display("test pins done");
        give_verdict();
    end
endmodule
bind serial_port_control serial_port_control_chk i_chk (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .tx_done_evt(tx_done_evt),
    .rx_done_evt(rx_done_evt), .rx_fault_evt(rx_fault_evt),
    .frame_cfg(frame_cfg), .timer_underflow(timer_underflow),
    .ser_clk_en(ser_clk_en), .irq(irq));
